// >>> logic/ufs_core.sv
// Serial transceiver with frame format control, baud divider and a
// master SPI mode, reached over AXI4-Lite.
// Assumes serial_in_pin is synchronous to aclk.
`timescale 1ns/1ns

// Overview of operation
// - Mode field picks async, sync or SPI
// - Transmitter appends even or odd parity
// - Receiver flags parity mismatch
// - Stop select gives one or two stops
// - Size code sets five to nine bits
// - Sync polarity picks change and sample edges
// - Divider is high nibble plus low byte
// - Low byte write reloads the prescaler
// - SPI mode drops parity, start, stop
// - SPI clock is system over 2(div+1)
// - Polarity and phase give four modes
// - SPI frame is eight bits, chosen order
// - Frames chain, else line idles high
// - Two writes make one 16-bit transfer
// - Data write starts every SPI transfer
// - Error flags read zero in SPI mode
module ufs_core
    import ufs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic serial_clock_pin,
    output logic serial_clock_oe
);

    // Register state
    logic [7:0] fmt;
    logic rx_en, tx_en, csz_hi, tx_ninth_bit, ck_dir;
    logic [11:0] baud_div;
    logic baud_reload;
    // Bus holding registers
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    // Transmit side
    logic txb_full, tx_done;
    logic [8:0] txb_data;
    ufs_state_type tx_state;
    logic [12:0] tx_vec;
    logic [3:0] tx_left, ph;
    // Receive side
    logic [12:0] rx_cap;
    logic arx_busy;
    logic [3:0] arx_ph, arx_left;
    logic rxb_full, fe_q, dor_q, pe_q;
    logic [8:0] rxb_data;
    logic tick;

    // Format decode
    ufs_mode_type mode;
    logic mspi, is_async, par_en, par_odd, stop2, lsbf, cpol, cpha;
    logic [2:0] csz;
    logic [3:0] nbits, tx_total, rx_total, ph_last;
    assign mode = ufs_mode_type'(fmt[FM_MODE+:2]);
    assign mspi = (mode == UFS_MSPI);
    assign is_async = (mode == UFS_ASYNC);
    assign par_en = fmt[FM_PAR_EN] && !mspi;
    assign par_odd = fmt[FM_PAR_ODD];
    assign stop2 = fmt[FM_STOP];
    assign csz = {csz_hi, fmt[FM_CSZ+:2]};
    assign lsbf = fmt[FM_ORDER];
    // Sync mode behaves as phase one with the polarity bit
    assign cpol = !is_async && fmt[FM_POL];
    assign cpha = mspi ? fmt[FM_PHASE] : 1'b1;
    // Reserved size codes fall back to eight bits
    assign nbits = mspi ? SPI_BITS :
                   (csz == 3'h0) ? 4'h5 :
                   (csz == 3'h1) ? 4'h6 :
                   (csz == 3'h2) ? 4'h7 :
                   (csz == 3'h7) ? 4'h9 : 4'h8;
    assign tx_total = mspi ? SPI_BITS :
        4'h1 + nbits + {3'h0, par_en} + (stop2 ? 4'h2 : 4'h1);
    // Receiver checks only the first stop bit
    assign rx_total = is_async ?
        4'h1 + nbits + {3'h0, par_en} + 4'h1 : tx_total;
    assign ph_last = is_async ? PH_LAST_ASYNC : PH_LAST_SYNC;

    // Bus decode
    logic wr_fire, wr_data, wr_stat, wr_ctrl, wr_fmt, wr_baud;
    logic wr_map, rd_map, ar_fire, rd_pop;
    assign wr_fire = !awready && !wready && !bvalid;
    assign wr_data = wr_fire && aw_q == ADDR_DATA && ws_q[0];
    assign wr_stat = wr_fire && aw_q == ADDR_STAT && ws_q[0];
    assign wr_ctrl = wr_fire && aw_q == ADDR_CTRL;
    assign wr_fmt = wr_fire && aw_q == ADDR_FMT && ws_q[0];
    assign wr_baud = wr_fire && aw_q == ADDR_BAUD;
    assign wr_map = aw_q == ADDR_DATA || aw_q == ADDR_STAT ||
                    aw_q == ADDR_CTRL || aw_q == ADDR_FMT ||
                    aw_q == ADDR_BAUD;
    assign rd_map = araddr == ADDR_DATA || araddr == ADDR_STAT ||
                    araddr == ADDR_CTRL || araddr == ADDR_FMT ||
                    araddr == ADDR_BAUD;
    assign ar_fire = arvalid && arready;
    assign rd_pop = ar_fire && araddr == ADDR_DATA;

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_q <= wdata;
                ws_q <= wstrb;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Read words
    logic [31:0] stat_word, ctrl_word, rd_word;
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ST_RXC] = rxb_full;
        stat_word[ST_TXC] = tx_done;
        stat_word[ST_DRE] = !txb_full;
        stat_word[ST_FE] = fe_q && !mspi;
        stat_word[ST_DOR] = dor_q && !mspi;
        stat_word[ST_PE] = pe_q && !mspi;
        ctrl_word = 32'h0000_0000;
        ctrl_word[CT_CKDIR] = ck_dir;
        ctrl_word[CT_RXEN] = rx_en;
        ctrl_word[CT_TXEN] = tx_en;
        ctrl_word[CT_CSZH] = csz_hi;
        ctrl_word[CT_RX9] = rxb_data[8];
        ctrl_word[CT_TX9] = tx_ninth_bit;
    end
    // Reserved divider bits always read zero
    assign rd_word = (araddr == ADDR_DATA) ? {23'h0, rxb_data} :
                     (araddr == ADDR_STAT) ? stat_word :
                     (araddr == ADDR_CTRL) ? ctrl_word :
                     (araddr == ADDR_FMT) ? {24'h0, fmt} :
                     (araddr == ADDR_BAUD) ? {20'h0, baud_div} :
                     32'h0000_0000;

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt <= FMT_RESET;
            {rx_en, tx_en, csz_hi, tx_ninth_bit, ck_dir} <= 5'h00;
            baud_div <= BAUD_RESET;
            baud_reload <= 1'b0;
        end else if (ce) begin
            if (wr_fmt) begin
                fmt <= w_q[7:0];
            end
            if (wr_ctrl && ws_q[0]) begin
                rx_en <= w_q[CT_RXEN];
                tx_en <= w_q[CT_TXEN];
                csz_hi <= w_q[CT_CSZH];
                tx_ninth_bit <= w_q[CT_TX9];
            end
            if (wr_ctrl && ws_q[1]) begin
                ck_dir <= w_q[CT_CKDIR];
            end
            if (wr_baud && ws_q[0]) begin
                baud_div[7:0] <= w_q[7:0];
            end
            // Upper four bits of the high byte are dropped
            if (wr_baud && ws_q[1]) begin
                baud_div[11:8] <= w_q[BD_HI_MSB:BD_HI_LSB];
            end
            // Reload lags one cycle so the new value is in place
            baud_reload <= wr_baud && ws_q[0];
        end
    end

    ufs_baud_gen u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .reload(baud_reload),
        .div(baud_div),
        .tick(tick)
    );

    // Frame assembly from the transmit buffer
    logic [12:0] frame_vec;
    logic tx_par;
    always_comb begin
        frame_vec = 13'h1fff;
        tx_par = par_odd;
        for (int i = 0; i < 9; i++) begin
            if (i < nbits) begin
                tx_par = tx_par ^ txb_data[i];
            end
        end
        if (mspi) begin
            for (int i = 0; i < 8; i++) begin
                frame_vec[i] = lsbf ? txb_data[i] : txb_data[7-i];
            end
        end else begin
            frame_vec[0] = 1'b0;
            for (int i = 0; i < 9; i++) begin
                if (i < nbits) begin
                    frame_vec[i+1] = txb_data[i];
                end
            end
            if (par_en) begin
                frame_vec[nbits+4'h1] = tx_par;
            end
        end
    end

    // Engine control
    logic shifting, bit_end, frame_end, load, data_ok;
    assign shifting = (tx_state == UFS_SHIFT);
    assign bit_end = shifting && tick && ph == ph_last;
    assign frame_end = bit_end && tx_left == 4'h1;
    // Next frame starts right at the end of the last one
    assign load = txb_full && tx_en && tick &&
                  (!shifting || frame_end);
    assign data_ok = wr_data && !txb_full;

    // Transmit buffer and completion flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txb_full <= 1'b0;
            txb_data <= 9'h000;
            tx_done <= 1'b0;
        end else if (ce) begin
            if (data_ok) begin
                txb_full <= 1'b1;
                txb_data <= {tx_ninth_bit, w_q[7:0]};
            end else if (load) begin
                txb_full <= 1'b0;
            end
            // Completion waits for an empty buffer; set beats clear
            if (frame_end && !txb_full) begin
                tx_done <= 1'b1;
            end else if (wr_stat && w_q[ST_TXC]) begin
                tx_done <= 1'b0;
            end
        end
    end

    // Shared shift engine for all three modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= UFS_IDLE;
            tx_vec <= 13'h1fff;
            tx_left <= 4'h0;
            ph <= 4'h0;
        end else if (ce) begin
            if (load) begin
                tx_state <= UFS_SHIFT;
                tx_vec <= frame_vec;
                tx_left <= tx_total;
                ph <= 4'h0;
            end else if (bit_end) begin
                ph <= 4'h0;
                tx_vec <= {1'b1, tx_vec[12:1]};
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h1) begin
                    tx_state <= UFS_IDLE;
                end
            end else if (shifting && tick) begin
                ph <= ph + 4'h1;
            end
        end
    end

    // Pins: one cycle behind the engine, data and clock alike
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
            serial_clock_pin <= 1'b0;
            serial_clock_oe <= 1'b0;
        end else if (ce) begin
            serial_out_pin <= shifting ? tx_vec[0] : 1'b1;
            serial_out_oe <= tx_en;
            serial_clock_oe <= ck_dir;
            if (shifting && !is_async) begin
                serial_clock_pin <= cpol ^
                    (cpha ? ph == 4'h0 : ph == 4'h1);
            end else begin
                serial_clock_pin <= cpol;
            end
        end
    end

    // Receive sampling: sync modes at mid bit, async at tick seven
    logic sync_smp, sync_done, async_go, async_smp, async_done, rx_done;
    logic [12:0] cap_in, rx_src, rx_ext;
    assign sync_smp = shifting && tick && ph == 4'h0 && !is_async && rx_en;
    assign sync_done = frame_end && !is_async && rx_en;
    assign async_go = is_async && rx_en && !arx_busy && !serial_in_pin;
    assign async_smp = arx_busy && tick && arx_ph == PH_MID_ASYNC;
    assign async_done = async_smp && arx_left == 4'h1;
    assign rx_done = sync_done || async_done;
    assign cap_in = {serial_in_pin, rx_cap[12:1]};
    assign rx_src = async_done ? cap_in : rx_cap;
    assign rx_ext = rx_src >> (FRAME_MAX - rx_total);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cap <= 13'h0000;
            arx_busy <= 1'b0;
            arx_ph <= 4'h0;
            arx_left <= 4'h0;
        end else if (ce) begin
            if (sync_smp || async_smp) begin
                rx_cap <= cap_in;
            end
            if (async_go) begin
                arx_busy <= 1'b1;
                arx_ph <= 4'h0;
                arx_left <= rx_total;
            end else if (arx_busy && tick) begin
                arx_ph <= arx_ph + 4'h1;
                if (async_smp) begin
                    arx_left <= arx_left - 4'h1;
                    arx_busy <= arx_left != 4'h1;
                end
            end
            if (!is_async || !rx_en) begin
                arx_busy <= 1'b0;
            end
        end
    end

    // Received frame unpacking and checks
    logic [8:0] rx_word;
    logic rx_perr, rx_ferr;
    always_comb begin
        rx_word = 9'h000;
        if (mspi) begin
            for (int i = 0; i < 8; i++) begin
                rx_word[i] = lsbf ? rx_ext[i] : rx_ext[7-i];
            end
        end else begin
            for (int i = 0; i < 9; i++) begin
                if (i < nbits) begin
                    rx_word[i] = rx_ext[i+1];
                end
            end
        end
        rx_perr = par_en &&
            (rx_ext[nbits+4'h1] != (par_odd ^ (^rx_word)));
        rx_ferr = !mspi && !rx_ext[nbits+4'h1+{3'h0, par_en}];
    end

    // Receive buffer with status held until the data is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxb_full <= 1'b0;
            rxb_data <= 9'h000;
            {fe_q, dor_q, pe_q} <= 3'h0;
        end else if (ce) begin
            if (!rx_en) begin
                rxb_full <= 1'b0;
                {fe_q, dor_q, pe_q} <= 3'h0;
            end else if (rx_done && (!rxb_full || rd_pop)) begin
                rxb_full <= 1'b1;
                rxb_data <= rx_word;
                fe_q <= rx_ferr;
                pe_q <= rx_perr;
                dor_q <= 1'b0;
            end else if (rx_done) begin
                dor_q <= 1'b1;
            end else if (rd_pop) begin
                rxb_full <= 1'b0;
                {fe_q, dor_q, pe_q} <= 3'h0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    property p_spi_flags;
        mspi |-> stat_word[ST_FE:ST_PE] == 3'h0;
    endproperty
    a_spi_flags: assert property (p_spi_flags) else $error("flags set");

    property p_spi_len;
        (load && mspi) |=> tx_left == 4'h8 && tx_state == UFS_SHIFT;
    endproperty
    a_spi_len: assert property (p_spi_len) else $error("spi length");

    property p_size5;
        (load && is_async && csz == 3'h0 && !fmt[FM_PAR_EN] && !stop2)
            |=> tx_left == 4'h7 && !tx_vec[0];
    endproperty
    a_size5: assert property (p_size5) else $error("size five");

    property p_two_stop;
        (load && !mspi && csz == 3'h3 && !par_en && stop2)
            |=> tx_left == 4'hb && tx_vec[10:9] == 2'h3;
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("two stop");

    property p_even;
        (load && !mspi && fmt[5:4] == 2'h2 && csz == 3'h3)
            |=> ^tx_vec[9:1] == 1'b0;
    endproperty
    a_even: assert property (p_even) else $error("even parity");

    property p_perr;
        (rx_done && rx_en && !rxb_full && rx_perr) |=> pe_q && rxb_full;
    endproperty
    a_perr: assert property (p_perr) else $error("parity flag");

    property p_idle_high;
        (!shifting && $past(!shifting)) |-> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("not idle");

    property p_done_empty;
        $rose(tx_done) |-> !shifting && $past(!txb_full);
    endproperty
    a_done_empty: assert property (p_done_empty) else $error("early done");

    property p_start;
        (txb_full && tx_en && !shifting && tick) |=> shifting && !txb_full;
    endproperty
    a_start: assert property (p_start) else $error("no start");

    property p_clk_idle;
        (!shifting && $past(!shifting)) |-> serial_clock_pin == $past(cpol);
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock idle");

    c_spi_chain: cover property (frame_end && load && mspi);
    c_async_rx: cover property (async_done && !rx_perr);
    c_tx_done: cover property ($rose(tx_done));

endmodule

// >>> include/ufs_pkg.sv
// Shared constants for the serial frame and master SPI block.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
package ufs_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_FMT = 8'h0c;
    localparam logic [7:0] ADDR_BAUD = 8'h10;

    // Reset values
    localparam logic [7:0] FMT_RESET = 8'h06;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // Status register bit positions
    localparam int ST_RXC = 7;
    localparam int ST_TXC = 6;
    localparam int ST_DRE = 5;
    localparam int ST_FE = 4;
    localparam int ST_DOR = 3;
    localparam int ST_PE = 2;

    // Control register bit positions
    localparam int CT_CKDIR = 8;
    localparam int CT_RXEN = 4;
    localparam int CT_TXEN = 3;
    localparam int CT_CSZH = 2;
    localparam int CT_RX9 = 1;
    localparam int CT_TX9 = 0;

    // Frame format field positions
    localparam int FM_MODE = 6;
    localparam int FM_PAR_EN = 5;
    localparam int FM_PAR_ODD = 4;
    localparam int FM_STOP = 3;
    localparam int FM_CSZ = 1;
    localparam int FM_ORDER = 2;
    localparam int FM_PHASE = 1;
    localparam int FM_POL = 0;

    // Baud divider byte layout
    localparam int BD_HI_LSB = 8;
    localparam int BD_HI_MSB = 11;

    // Bit timing: last tick index of one bit and async sample tick
    localparam logic [3:0] PH_LAST_ASYNC = 4'hf;
    localparam logic [3:0] PH_LAST_SYNC = 4'h1;
    localparam logic [3:0] PH_MID_ASYNC = 4'h7;
    localparam logic [3:0] SPI_BITS = 4'h8;
    localparam logic [3:0] FRAME_MAX = 4'hd;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        UFS_ASYNC = 2'b00,
        UFS_SYNC = 2'b01,
        UFS_RSVD = 2'b10,
        UFS_MSPI = 2'b11
    } ufs_mode_type;

    typedef enum logic [1:0] {
        UFS_IDLE = 2'b00,
        UFS_SHIFT = 2'b01
    } ufs_state_type;

endpackage

// >>> logic/ufs_baud_gen.sv
// Baud prescaler: one tick every divider-plus-one enabled cycles.
// Assumes the divider is stable except when reload is pulsed.
`timescale 1ns/1ns
module ufs_baud_gen
    import ufs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic reload,
    input wire logic [11:0] div,
    output logic tick
);

    logic [11:0] cnt;

    // Tick marks half a clock period in sync modes
    assign tick = ce && (cnt == 12'h000);

    // Count down, restart on tick or on a divider reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= BAUD_RESET;
        end else if (ce) begin
            if (reload || cnt == 12'h000) begin
                cnt <= div;
            end else begin
                cnt <= cnt - 12'h001;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    property p_reload;
        reload |=> cnt == $past(div);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");

    property p_period;
        (tick && !reload) |=> (cnt == $past(div)) ##1
            (cnt != $past(cnt) || $past(reload) || $past(div) == 12'h000);
    endproperty
    a_period: assert property (p_period) else $error("bad period");

endmodule

// >>> tb/ufs_peer.sv
// SPI slave model for mode 0, most significant bit first.
// Assumes the serial clock half period is two or more aclk cycles.
`timescale 1ns/1ns
module ufs_peer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got,
    output logic [7:0] frames
);
    logic sck_d;
    logic [7:0] tx;
    logic [2:0] n;
    assign miso = tx[7];
    // Sample on the rising clock and present the next bit right after,
    // so the bit is settled long before the master's next sample
    always_ff @(posedge aclk) begin
        sck_d <= sck;
        if (!aresetn) begin
            tx <= reply;
            n <= 3'h0;
            frames <= 8'h00;
        end else if (sck && !sck_d) begin
            got <= {got[6:0], mosi};
            n <= n + 3'h1;
            frames <= frames + {7'h00, n == 3'h7};
            // Reload only between frames so a byte is never split
            tx <= (n == 3'h7) ? reply : {tx[6:0], 1'b0};
        end
    end
endmodule

// >>> tb/ufs_core_bench.sv
// Bench for the serial frame block: registers and SPI transfers.
// Assumes the peer model answers in SPI mode 0.
`timescale 1ns/1ns
module ufs_core_bench;
    import ufs_pkg::*;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, reply, got, frames;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, bs;
    logic awready, wready, bvalid, arready, rvalid;
    logic sin, sout, soe, sck, sckoe;
    int fails, comparisons;
    ufs_core ufs_core_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_in_pin(sin), .serial_out_pin(sout), .serial_out_oe(soe),
        .serial_clock_pin(sck), .serial_clock_oe(sckoe));
    ufs_peer ufs_peer_i (.aclk(aclk), .aresetn(aresetn), .sck(sck),
        .mosi(sout), .reply(reply), .miso(sin), .got(got),
        .frames(frames));
    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Each channel drops valid at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bs = bresp;
                ok = 1'b1;
                break;
            end
        end
        bready <= 1'b0;
        // A response that never comes counts as a mismatch
        chk({31'h0, ok}, 32'h1);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk({31'h0, ok}, 32'h1);
    endtask
    // Poll until the transmit complete flag shows
    task automatic wait_txc();
        repeat (200) begin
            rd_reg(ADDR_STAT);
            if (rd[ST_TXC] === 1'b1) break;
        end
        chk({31'h0, rd[ST_TXC]}, 32'h1);
    endtask
    // Watchdog: the whole sequence needs about a thousand cycles
    initial begin
        #100000;
        fails++;
        finish_test();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        ce = 1'b1;
        wstrb = 4'hf;
        aresetn = 1'b0;
        reply = 8'h3c;
        fails = 0;
        comparisons = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(ADDR_FMT);
        chk(rd, 32'h06);
        rd_reg(ADDR_STAT);
        chk(rd, 32'h20);
        wr(ADDR_BAUD, 32'h0abc);
        chk({30'h0, bs}, 32'h0);
        rd_reg(ADDR_BAUD);
        chk(rd, 32'h0abc);
        rd_reg(8'h7c);
        chk({30'h0, rs}, 32'h2);
        wr(8'h7c, 32'h0);
        chk({30'h0, bs}, 32'h2);
        // Slow divider keeps the peer's edge detection safe
        wr(ADDR_BAUD, 32'h1);
        wr(ADDR_FMT, 32'hc0);
        wr(ADDR_CTRL, 32'h118);
        wr(ADDR_DATA, 32'ha5);
        chk({30'h0, soe, sckoe}, 32'h3);
        wait_txc();
        chk({24'h0, got}, 32'ha5);
        rd_reg(ADDR_DATA);
        chk({24'h0, rd[7:0]}, 32'h3c);
        rd_reg(ADDR_STAT);
        chk(rd & 32'h1c, 32'h0);
        wr(ADDR_STAT, 32'h40);
        wr(ADDR_DATA, 32'h12);
        wr(ADDR_DATA, 32'h34);
        rd_reg(ADDR_STAT);
        chk({31'h0, rd[ST_TXC]}, 32'h0);
        wait_txc();
        chk({24'h0, frames}, 32'h3);
        chk({24'h0, got}, 32'h34);
        chk({30'h0, sout, sck}, 32'h2);
        wr(ADDR_STAT, 32'h40);
        wr(ADDR_FMT, 32'hc4);
        wr(ADDR_DATA, 32'h01);
        wait_txc();
        chk({24'h0, got}, 32'h80);
        // Async frames: two stop bits, then even parity
        wr(ADDR_STAT, 32'h40);
        wr(ADDR_FMT, 32'h0e);
        wr(ADDR_DATA, 32'h5a);
        wait_txc();
        wr(ADDR_STAT, 32'h40);
        wr(ADDR_FMT, 32'h26);
        wr(ADDR_DATA, 32'h5a);
        wait_txc();
        chk({31'h0, sout}, 32'h1);
        finish_test();
    end
endmodule
